// ==== dv/bus_host.sv ====
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Host side of the nibble bus
// ****************************************
// Phase clock stands still low outside accesses except for the idle task's free pulses, which carry reset into the device
module bus_host (
    output var logic       phase_o,   // Bus phase clock
    output var logic       cs_n_o,    // Chip select, active low
    output var logic       rw_o,      // 1 = read
    output var logic       sel_o,     // Register select
    output var logic [3:0] d_o,       // Host bus drive
    input  wire logic [3:0] dev_d_i,  // Device read data
    input  wire logic      dev_oe_i   // Device drives the bus
);
    initial begin
        phase_o = 1'b0;
        cs_n_o  = 1'b1;
        rw_o    = 1'b1;
        sel_o   = 1'b0;
        d_o     = 4'h5;
    end

    // One access: set up with phase low, phase high, data taken at the fall
    task automatic access(input logic cs_n, input logic rw, input logic sel, input logic [3:0] wd,
                          output logic [3:0] rd, output logic oe_lo, output logic oe_hi);
        cs_n_o = cs_n;
        rw_o   = rw;
        sel_o  = sel;
        if (!rw) begin
            d_o = wd;
        end
        #8;
        oe_lo   = dev_oe_i;
        phase_o = 1'b1;
        #7;
        rd      = dev_d_i;
        oe_hi   = dev_oe_i;
        phase_o = 1'b0;
        #8;
        // Released lines show the inverse, not a stale copy of the last value
        cs_n_o = 1'b1;
        d_o    = ~d_o;
        #200;
    endtask

    // Free phase pulses with the device deselected, used across reset
    task automatic idle(input int n);
        repeat (n) begin
            #8 phase_o = 1'b1;
            #7 phase_o = 1'b0;
        end
    endtask
endmodule // bus_host

`default_nettype wire

// ==== dv/dtmf_transceiver_host_port_bench.sv ====
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("mismatch %s exp %h got %h", nm, e, g); end end

module dtmf_transceiver_host_port_bench;
    import tone_port_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic       clock_i = 1'b0;  // Core clock
    logic       srst_i  = 1'b1;  // Synchronous reset
    logic       phase, cs_n, rw, sel;
    logic [3:0] hd, dout, bus_w;
    logic       dout_oe, irq_o, irq_oe, early_pair_detect, guard, guard_oe, xout, xout_oe;
    logic       pv = 1'b0;       // Pair valid
    logic [3:0] pcode = 4'h0;    // Pair code
    logic       psq = 1'b1;      // Progress comparator
    logic       steer = 1'b0;    // Steering pin level
    logic       xin = 1'b0;      // Oscillator input
    logic       ext = 1'b0;      // External clock strap
    tone_cmd_t  tc, exp_tc;
    int         error_cnt = 0;
    int         checked = 0;
    int         cycles = 0;
    integer     seed = 31641;
    logic [3:0] rdv, code;
    logic       sg, hg, lo, hi;

    // Bus wire: device wins while it drives, else the host's level
    assign bus_w = dout_oe ? dout : hd;

    // ****************************************
    // Instances
    // ****************************************
    bus_host i_host (.phase_o(phase), .cs_n_o(cs_n), .rw_o(rw), .sel_o(sel), .d_o(hd),
                     .dev_d_i(dout), .dev_oe_i(dout_oe));

    // Short settle count keeps steering runs brief
    dtmf_transceiver_host_port #(.SETTLE_CYCLES(3)) i_dut (
        .clock_i(clock_i), .srst_i(srst_i), .bus_phase_clk_i(phase), .chip_sel_n_i(cs_n),
        .read_write_i(rw), .register_select_line_i(sel), .host_nibble_bus_i(bus_w),
        .host_nibble_bus_o(dout), .host_nibble_bus_oe_o(dout_oe), .interrupt_or_progress_o(irq_o),
        .interrupt_or_progress_oe_o(irq_oe), .pair_valid_i(pv), .pair_code_i(pcode),
        .progress_square_i(psq), .early_pair_detect_o(early_pair_detect), .pair_latch_threshold_pin_i(steer),
        .pair_latch_threshold_pin_o(guard), .pair_latch_threshold_pin_oe_o(guard_oe),
        .crystal_in_i(xin), .ext_clock_mode_i(ext), .crystal_out_o(xout),
        .crystal_out_oe_o(xout_oe), .tone_cmd_o(tc));

    // ****************************************
    // Clock, timeout, verdict
    // ****************************************
    initial begin
        forever #20 clock_i = ~clock_i;
    end

    // A hang counts as a failure and still reaches the report
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end

    // Open-drain pin never drives high; guard pin output always enabled
    always @(negedge clock_i) begin
        `CHK("irq_level", 1'b0, irq_o)
        `CHK("guard_oe", 1'b1, guard_oe)
    end

    task automatic results();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic bus_wr(input logic s, input logic [3:0] d);
        i_host.access(1'b0, 1'b0, s, d, rdv, lo, hi);
        `CHK("wr_oe", 1'b0, hi)
    endtask

    task automatic bus_rd(input logic s, output logic [3:0] d);
        i_host.access(1'b0, 1'b1, s, 4'h0, d, lo, hi);
        `CHK("rd_oe_low_phase", 1'b0, lo)
        `CHK("rd_oe_high_phase", 1'b1, hi)
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    // Expected tone command: enable set, fields as written through B and data
    function automatic tone_cmd_t exp_tone(input logic s, input logic h, input logic [3:0] c);
        return '{enable: 1'b1, single: s, high_grp: h, code: c};
    endfunction

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        i_host.idle(6);
        wait_cyc(8);
        `CHK("rst_est", 1'b0, early_pair_detect)
        `CHK("rst_guard", 1'b0, guard)
        `CHK("rst_irq_oe", 1'b0, irq_oe)
        `CHK("rst_tone", 7'h00, tc)
        srst_i = 1'b0;
        wait_cyc(4);
        i_host.idle(3);
        // Oscillator pins
        for (int i = 0; i < 4; i++) begin
            @(negedge clock_i);
            xin = 1'($random(seed));
            ext = i[0];
            wait_cyc(4);
            `CHK("xtal_out", ~xin, xout)
            `CHK("xtal_oe", ~ext, xout_oe)
        end
        // Tone command through control A, control B and transmit data
        for (int i = 0; i < 4; i++) begin
            code = 4'($random(seed));
            sg   = 1'($random(seed));
            hg   = 1'($random(seed));
            bus_wr(1'b1, 4'h9);
            bus_wr(1'b1, {2'b00, hg, sg});
            bus_wr(1'b0, code);
            wait_cyc(6);
            exp_tc = exp_tone(sg, hg, code);
            `CHK("tone_cmd", exp_tc, tc)
            i_host.access(1'b1, 1'b0, 1'b0, ~code, rdv, lo, hi);
            wait_cyc(6);
            `CHK("tone_deselected", exp_tc, tc)
            `CHK("oe_deselected", 1'b0, hi)
        end
        // Early detect follows pair valid one cycle late
        for (int i = 0; i < 40; i++) begin
            pv = 1'($random(seed));
            @(negedge clock_i);
            `CHK("early_detect", pv, early_pair_detect)
        end
        // Steering with interrupt enabled
        bus_wr(1'b1, 4'h4);
        @(negedge clock_i);
        pv    = 1'b1;
        steer = 1'b1;
        @(negedge clock_i);
        steer = 1'b0;
        wait_cyc(20);
        `CHK("abort_irq", 1'b0, irq_oe)
        for (int i = 0; i < 3; i++) begin
            code  = 4'($random(seed));
            pcode = code;
            pv    = 1'b1;
            steer = 1'b1;
            wait_cyc(20);
            `CHK("steer_irq", 1'b1, irq_oe)
            `CHK("guard_high", 1'b1, guard)
            bus_rd(1'b1, rdv);
            `CHK("status_dstf", 1'b1, rdv[1])
            `CHK("status_est", 1'b1, rdv[2])
            `CHK("status_st", 1'b1, rdv[3])
            `CHK("status_irq", 1'b1, rdv[0])
            bus_rd(1'b0, rdv);
            `CHK("rx_data", code, rdv)
            pcode = ~code;
            wait_cyc(10);
            `CHK("irq_cleared", 1'b0, irq_oe)
            pv    = 1'b0;
            steer = 1'b0;
            wait_cyc(10);
            `CHK("guard_low", 1'b0, guard)
        end
        // Progress mode with interrupt enabled
        bus_wr(1'b1, 4'h6);
        @(negedge clock_i);
        pv = 1'b1;
        for (int i = 0; i < 8; i++) begin
            psq = (i < 2) ? i[0] : 1'($random(seed));
            wait_cyc(5);
            `CHK("progress_wave", ~psq, irq_oe)
            `CHK("progress_no_est", 1'b0, early_pair_detect)
        end
        bus_wr(1'b1, 4'h0);
        results();
    end
endmodule // dtmf_transceiver_host_port_bench

`default_nettype wire

// ==== hw/dtmf_transceiver_host_port.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "tone_port_defines.svh"

module dtmf_transceiver_host_port
    import tone_port_pkg::*;
#(
    parameter int SETTLE_CYCLES = `SETTLE_CYC
) (
    input  wire logic       clock_i,
    input  wire logic       srst_i,
    input  wire logic       bus_phase_clk_i,
    input  wire logic       chip_sel_n_i,
    input  wire logic       read_write_i,
    input  wire logic       register_select_line_i,
    input  wire logic [3:0] host_nibble_bus_i,
    output logic      [3:0] host_nibble_bus_o,
    output logic            host_nibble_bus_oe_o,
    output logic            interrupt_or_progress_o,
    output logic            interrupt_or_progress_oe_o,
    input  wire logic       pair_valid_i,
    input  wire logic [3:0] pair_code_i,
    input  wire logic       progress_square_i,
    output logic            early_pair_detect_o,
    input  wire logic       pair_latch_threshold_pin_i,
    output logic            pair_latch_threshold_pin_o,
    output logic            pair_latch_threshold_pin_oe_o,
    input  wire logic       crystal_in_i,
    input  wire logic       ext_clock_mode_i,
    output logic            crystal_out_o,
    output logic            crystal_out_oe_o,
    output tone_cmd_t       tone_cmd_o
);

    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) begin : g_bad_settle
        $error("dtmf_transceiver_host_port: SETTLE_CYCLES out of 1..255");
    end

    // ****************************************
    // Bus phase clock domain
    // ****************************************

    logic       link_rst;                 // Reset carried into the phase domain
    host_word_t wr_word_q, wr_word_d;     // Last written nibble, held stable
    logic       wr_tog_q, wr_tog_d;       // Flips once per write
    logic       rd_tog_q, rd_tog_d;       // Flips once per receive data read

    level_sync #(.WIDTH(1)) u_link_rst (
        .clk_i   (bus_phase_clk_i),
        .srst_i  (1'b0),
        .async_i (srst_i),
        .sync_o  (link_rst)
    );

    // Next values: capture at the falling phase edge of a selected cycle
    always_comb begin
        wr_word_d = wr_word_q;
        wr_tog_d  = wr_tog_q;
        rd_tog_d  = rd_tog_q;
        if (link_rst) begin
            wr_word_d = '0;
            wr_tog_d  = 1'b0;
            rd_tog_d  = 1'b0;
        end else if (!chip_sel_n_i) begin
            if (!read_write_i) begin
                wr_word_d = '{rsel: register_select_line_i, data: host_nibble_bus_i};
                wr_tog_d  = !wr_tog_q;
            end else if (register_select_line_i == `RSEL_DATA) begin
                rd_tog_d  = !rd_tog_q;
            end
        end
    end

    // Registers; the phase clock may stop between accesses, so nothing here
    // waits on a later edge: each access is complete at its own fall
    always_ff @(negedge bus_phase_clk_i) begin
        wr_word_q <= wr_word_d;
        wr_tog_q  <= wr_tog_d;
        rd_tog_q  <= rd_tog_d;
    end

    // ****************************************
    // Crossings into the core clock
    // ****************************************

    logic [4:0] sync_v;     // Toggles and pins after two flops
    logic       wr_tog_s;   // Synced write toggle
    logic       rd_tog_s;   // Synced read toggle
    logic       st_s;       // Synced steering level
    logic       prog_s;     // Synced progress comparator
    logic       ext_s;      // Synced clock source strap

    level_sync #(.WIDTH(5)) u_core_sync (
        .clk_i   (clock_i),
        .srst_i  (srst_i),
        .async_i ({ext_clock_mode_i, progress_square_i, pair_latch_threshold_pin_i,
                   rd_tog_q, wr_tog_q}),
        .sync_o  (sync_v)
    );

    assign {ext_s, prog_s, st_s, rd_tog_s, wr_tog_s} = sync_v;

    // ****************************************
    // Core registers
    // ****************************************

    logic         wr_seen_q, wr_seen_d;   // Last toggle value acted on
    logic         rd_seen_q, rd_seen_d;
    logic         wr_pulse;               // One cycle per host write
    logic         rd_pulse;               // One cycle per receive read
    logic [3:0]   ctla_q, ctla_d;         // Control A
    logic [3:0]   ctlb_q, ctlb_d;         // Control B
    logic [3:0]   tx_q, tx_d;             // Transmit data
    logic [3:0]   rx_q, rx_d;             // Receive data
    logic [3:0]   pend_q, pend_d;         // Pair held during settling
    logic         dstf_q, dstf_d;         // Delayed steering flag
    logic         est_q, est_d;           // Early detect
    logic         gt_q, gt_d;             // Guard time drive
    steer_state_t state_q, state_d;       // Steering sequence
    logic [7:0]   cnt_q, cnt_d;           // Settle countdown
    logic         cp_mode;
    logic         irq_en;
    logic         dstf_set;               // Pair registered this cycle

    assign wr_pulse = wr_tog_s != wr_seen_q;
    assign rd_pulse = rd_tog_s != rd_seen_q;
    assign cp_mode  = ctla_q[`CTLA_CP_MODE];
    assign irq_en   = ctla_q[`CTLA_IRQ_EN];
    assign dstf_set = state_q == ST_SETTLE && cnt_q == 8'h00 && st_s;

    // Next values: host writes and the steering sequence
    always_comb begin
        wr_seen_d = wr_tog_s;
        rd_seen_d = rd_tog_s;
        ctla_d    = ctla_q;
        ctlb_d    = ctlb_q;
        tx_d      = tx_q;
        rx_d      = rx_q;
        pend_d    = pend_q;
        dstf_d    = dstf_q;
        state_d   = state_q;
        cnt_d     = cnt_q;
        // Early detect is blocked while progress mode is chosen
        est_d     = pair_valid_i && !cp_mode;
        // Guard drive rises with both high, falls with both low, else holds
        gt_d      = (est_q && st_s) || (gt_q && (est_q || st_s));
        // Write decode by select and the control A select-B bit
        if (wr_pulse) begin
            if (wr_word_q.rsel == `RSEL_DATA) begin
                tx_d = wr_word_q.data;
            end else if (ctla_q[`CTLA_SEL_B]) begin
                // One write reaches B, then writes go back to A
                ctlb_d                = wr_word_q.data;
                ctla_d[`CTLA_SEL_B]   = 1'b0;
            end else begin
                ctla_d = wr_word_q.data;
            end
        end
        // Reading received data clears the flag
        if (rd_pulse) begin
            dstf_d = 1'b0;
        end
        unique case (state_q)
            ST_IDLE: begin
                // Armed: steering rise registers the current pair
                if (st_s) begin
                    pend_d  = pair_code_i;
                    cnt_d   = 8'(SETTLE_CYCLES - 1);
                    state_d = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // Let the latch settle before flagging
                if (!st_s) begin
                    state_d = ST_IDLE;
                end else if (cnt_q == 8'h00) begin
                    rx_d    = pend_q;
                    state_d = ST_HELD;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            ST_HELD: begin
                // Steering fall frees the receiver
                if (!st_s) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // Set wins over a read in the same cycle
        if (dstf_set) begin
            dstf_d = 1'b1;
        end
        if (srst_i) begin
            wr_seen_d = 1'b0;
            rd_seen_d = 1'b0;
            ctla_d    = `CTL_RESET;
            ctlb_d    = `CTL_RESET;
            tx_d      = `NIBBLE_RESET;
            rx_d      = `NIBBLE_RESET;
            pend_d    = `NIBBLE_RESET;
            dstf_d    = 1'b0;
            est_d     = 1'b0;
            gt_d      = 1'b0;
            state_d   = ST_IDLE;
            cnt_d     = 8'h00;
        end
    end

    // Registers
    always_ff @(posedge clock_i) begin
        wr_seen_q <= wr_seen_d;
        rd_seen_q <= rd_seen_d;
        ctla_q    <= ctla_d;
        ctlb_q    <= ctlb_d;
        tx_q      <= tx_d;
        rx_q      <= rx_d;
        pend_q    <= pend_d;
        dstf_q    <= dstf_d;
        est_q     <= est_d;
        gt_q      <= gt_d;
        state_q   <= state_d;
        cnt_q     <= cnt_d;
    end

    // ****************************************
    // Pins
    // ****************************************

    logic [3:0] status;   // Status register view

    assign status = {st_s, est_q, dstf_q, dstf_q && irq_en && !cp_mode};

    // Read data comes from core flops; they change only on rare events, so a
    // host read racing an update may see the old value, never a mix of bits
    assign host_nibble_bus_o = (register_select_line_i == `RSEL_CTRL) ? status : rx_q;
    // Released unless selected, reading and phase high
    assign host_nibble_bus_oe_o = !chip_sel_n_i && bus_phase_clk_i && read_write_i;

    // Open drain: output level low, enable pulls it down
    assign interrupt_or_progress_o = 1'b0;
    assign interrupt_or_progress_oe_o = irq_en && (cp_mode ? !prog_s : dstf_q);

    assign early_pair_detect_o           = est_q;
    assign pair_latch_threshold_pin_o    = gt_q;
    assign pair_latch_threshold_pin_oe_o = 1'b1;

    // Oscillator amplifier; released when an external clock drives the input
    assign crystal_out_o    = !crystal_in_i;
    assign crystal_out_oe_o = !ext_s;

    // Tone generator steering
    assign tone_cmd_o = '{enable:   ctla_q[`CTLA_TONE_EN],
                          single:   ctlb_q[`CTLB_SINGLE],
                          high_grp: ctlb_q[`CTLB_HIGH_GRP],
                          code:     tx_q};

    // ****************************************
    // Assertions
    // ****************************************

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    sequence s_registered;
        state_q == ST_SETTLE && cnt_q == 8'h00 && st_s;
    endsequence

    a_est_cp_block:  assert property (cp_mode |=> !early_pair_detect_o)
        else $error("early detect high in progress mode");
    a_est_rise:      assert property (pair_valid_i && !cp_mode |=> early_pair_detect_o)
        else $error("early detect missed valid pair");
    a_est_drop:      assert property (!pair_valid_i |=> !early_pair_detect_o)
        else $error("early detect held after loss");
    a_flag_set:      assert property (s_registered |=> dstf_q && state_q == ST_HELD)
        else $error("flag not set after settling");
    a_rx_latch:      assert property ($rose(dstf_q) |-> rx_q == $past(pend_q))
        else $error("receive data not latched");
    a_rearm:         assert property (state_q == ST_HELD && !st_s |=> state_q == ST_IDLE)
        else $error("no re-arm on steering fall");
    a_irq_pull:      assert property (!cp_mode && irq_en && dstf_q |-> interrupt_or_progress_oe_o)
        else $error("interrupt not pulled with flag");
    a_cp_wave:       assert property (cp_mode && irq_en |-> interrupt_or_progress_oe_o == !prog_s)
        else $error("progress wave wrong");
    a_bus_release:   assert property (chip_sel_n_i || !bus_phase_clk_i |-> !host_nibble_bus_oe_o)
        else $error("bus driven while deselected");
    a_guard_track:   assert property (est_q && st_s |=> gt_q ##1 (gt_q || !est_q))
        else $error("guard output not following");

endmodule // dtmf_transceiver_host_port

`default_nettype wire

// ==== hw/level_sync.sv ====
`timescale 1ns/1ns
`default_nettype none

module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // ****************************************
    // Two-flop synchroniser
    // ****************************************

    logic [WIDTH-1:0] meta_q, meta_d;  // First stage, read only by second
    logic [WIDTH-1:0] sync_q, sync_d;  // Second stage

    if (WIDTH < 1) begin : g_bad_width
        $error("level_sync: WIDTH must be at least 1");
    end

    // Next values
    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
        if (srst_i) begin
            meta_d = '0;
            sync_d = '0;
        end
    end

    // Registers
    always_ff @(posedge clk_i) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign sync_o = sync_q;

endmodule // level_sync

`default_nettype wire

// ==== hw/tone_port_defines.svh ====
`ifndef TONE_PORT_DEFINES_SVH
`define TONE_PORT_DEFINES_SVH

// ****************************************
// Register select codes
// ****************************************
`define RSEL_DATA        1'b0
`define RSEL_CTRL        1'b1

// ****************************************
// Control register A field positions
// ****************************************
`define CTLA_TONE_EN     0
`define CTLA_CP_MODE     1
`define CTLA_IRQ_EN      2
`define CTLA_SEL_B       3

// ****************************************
// Control register B field positions
// ****************************************
`define CTLB_SINGLE      0
`define CTLB_HIGH_GRP    1

// ****************************************
// Status register field positions
// ****************************************
`define STAT_IRQ         0
`define STAT_DSTF        1
`define STAT_EST         2
`define STAT_ST          3

// ****************************************
// Reset values
// ****************************************
`define CTL_RESET        4'h0
`define NIBBLE_RESET     4'h0

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS    40
`define SETTLE_TIME_NS   200
`define SETTLE_CYC       ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== hw/tone_port_pkg.sv ====
package tone_port_pkg;

    // ****************************************
    // Shared types
    // ****************************************

    // Word captured from the host on a write
    typedef struct packed {
        logic       rsel;   // Register select level
        logic [3:0] data;   // Written nibble
    } host_word_t;

    // Command to the tone generator
    typedef struct packed {
        logic       enable;    // Transmit on
        logic       single;    // Single tone instead of pair
        logic       high_grp;  // Group used for single tone
        logic [3:0] code;      // Tone pair code
    } tone_cmd_t;

    // Steering sequence
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SETTLE = 2'b01,
        ST_HELD   = 2'b10
    } steer_state_t;

endpackage
